// >>> common/wsm_pkg.sv
// Purpose: shared constants, tables and types of the wind threshold monitor
// Assumes: speeds are carried in units of 0.1 m/s
// Notes: the 8-bit external value scales against EXT8_TOP
package wsm_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned ONE_SEC_S = 1;
   localparam int unsigned TICK_CYC = ONE_SEC_S * CLK_HZ;
   localparam int unsigned CYC_STEP_S = 10;
   localparam int SPD_W = 16;
   localparam int SEC_W = 12;
   localparam int CYC_W = 11;
   localparam logic [CYC_W-1:0] CYC_STEP_TICKS = CYC_W'(CYC_STEP_S / ONE_SEC_S);
   localparam logic [6:0] CYC_MAX = 7'h78;
   localparam logic [SPD_W-1:0] EXT8_TOP = 16'h0190;
   localparam logic [3:0] MODE_PRI_ONLY = 4'h4;
   localparam logic [3:0] MODE_RET_ONLY = 4'h8;
   localparam logic [3:0] MODE_CNT = 4'hc;

   typedef enum logic [1:0] {EXT_NONE = 2'h0, EXT_16 = 2'h1, EXT_8 = 2'h2} ext_mode_e;
   typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_ON = 2'h1, ACT_OFF = 2'h2} act_e;

   function automatic logic [SPD_W-1:0] level_speed(input logic [3:0] sel);
      case (sel)
         4'h1: level_speed = 16'h000a;
         4'h2: level_speed = 16'h001e;
         4'h3: level_speed = 16'h0032;
         4'h4: level_speed = 16'h0050;
         4'h5: level_speed = 16'h0064;
         4'h6: level_speed = 16'h0078;
         4'h7: level_speed = 16'h0096;
         4'h8: level_speed = 16'h00c8;
         4'h9: level_speed = 16'h00dc;
         4'ha: level_speed = 16'h00fa;
         4'hb: level_speed = 16'h012c;
         4'hc: level_speed = 16'h015e;
         default: level_speed = 16'h000a;
      endcase
   endfunction

   function automatic logic [SPD_W-1:0] hyst_speed(input logic [2:0] sel);
      case (sel)
         3'h1: hyst_speed = 16'h000a;
         3'h2: hyst_speed = 16'h001e;
         3'h3: hyst_speed = 16'h0032;
         3'h4: hyst_speed = 16'h0050;
         3'h5: hyst_speed = 16'h0064;
         default: hyst_speed = 16'h0000;
      endcase
   endfunction

   function automatic logic [SEC_W-1:0] delay_secs(input logic [3:0] sel);
      case (sel)
         4'h1: delay_secs = 12'h001;
         4'h2: delay_secs = 12'h003;
         4'h3: delay_secs = 12'h005;
         4'h4: delay_secs = 12'h00a;
         4'h5: delay_secs = 12'h00f;
         4'h6: delay_secs = 12'h01e;
         4'h7: delay_secs = 12'h03c;
         4'h8: delay_secs = 12'h0b4;
         4'h9: delay_secs = 12'h12c;
         4'ha: delay_secs = 12'h258;
         4'hb: delay_secs = 12'h384;
         4'hc: delay_secs = 12'h708;
         4'hd: delay_secs = 12'he10;
         default: delay_secs = 12'h000;
      endcase
   endfunction

   function automatic logic [SPD_W-1:0] ext8_speed(input logic [7:0] v);
      logic [SPD_W+7:0] p;
      p = (SPD_W+8)'(v) * (SPD_W+8)'(EXT8_TOP);
      ext8_speed = p[SPD_W+7:8];
   endfunction
endpackage

// >>> common/timebase_if.sv
// Purpose: seconds tick and cyclic send timing between monitor modules
// Assumes: one clock domain
// Notes: due is a one-cycle pulse
interface timebase_if;
   logic tick;
   logic run;
   logic [6:0] cyc_sel;
   logic due;
   modport tick_src (output tick);
   modport cyc (input tick, input run, input cyc_sel, output due);
   modport core (input tick, input due, output run, output cyc_sel);
endinterface

// >>> core/one_sec_tick.sv
// Purpose: one-second tick from the system clock
// Assumes: P_TICK_CYC clock cycles per second
// Notes: tick is a one-cycle pulse, free running after reset
module one_sec_tick #(
   parameter int unsigned P_TICK_CYC = wsm_pkg::TICK_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   timebase_if.tick_src tb
);
   import wsm_pkg::*;
   localparam int CW = $clog2(P_TICK_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(P_TICK_CYC - 1);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = (cnt_ff == LAST);
      nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tb.tick = tick_ff;
endmodule

// >>> core/cycle_timer.sv
// Purpose: cyclic send timer, period of cyc_sel steps of ten seconds
// Assumes: cyc_sel already limited to its legal range
// Notes: restarts whenever disabled
module cycle_timer (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   timebase_if.cyc tb
);
   import wsm_pkg::*;
   logic [CYC_W-1:0] period;
   logic [CYC_W-1:0] cnt_ff;
   logic [CYC_W-1:0] nxt_cnt;
   logic due_ff;
   logic nxt_due;

   always_comb begin
      period = CYC_W'(tb.cyc_sel) * CYC_STEP_TICKS;
      nxt_cnt = cnt_ff;
      nxt_due = 1'b0;
      if (!tb.run || tb.cyc_sel == '0) begin
         nxt_cnt = '0;
      end else if (tb.tick) begin
         if (cnt_ff >= period - 1'b1) begin
            nxt_cnt = '0;
            nxt_due = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= '0;
         due_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         due_ff <= nxt_due;
      end
   end

   assign tb.due = due_ff;
endmodule

// >>> core/wind_speed_threshold_monitor.sv
// Purpose: second wind speed threshold monitor with delays and send control
// Assumes: i_speed is valid while i_speed_vld pulses; speeds in 0.1 m/s
// Notes: o_send is a one-cycle telegram request carrying o_send_val
module wind_speed_threshold_monitor #(
   parameter int unsigned P_TICK_CYC = wsm_pkg::TICK_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wind_en,
   input wire logic i_both_en,
   input wire logic [wsm_pkg::SPD_W-1:0] i_speed,
   input wire logic i_speed_vld,
   input wire logic [3:0] i_threshold_level,
   input wire logic [2:0] i_hyst_sel,
   input wire logic [3:0] i_action_sel,
   input wire logic [1:0] i_ext_mode,
   input wire logic [wsm_pkg::SPD_W-1:0] i_ext16,
   input wire logic i_ext16_wr,
   input wire logic [7:0] i_ext8,
   input wire logic i_ext8_wr,
   input wire logic [3:0] i_on_dly_sel,
   input wire logic [3:0] i_off_dly_sel,
   input wire logic i_send_chg,
   input wire logic [6:0] i_cyc_sel,
   output logic o_state,
   output logic o_send,
   output logic o_send_val,
   output logic o_active
);
   import wsm_pkg::*;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} dly_st_e;

   timebase_if tb ();

   one_sec_tick #(.P_TICK_CYC(P_TICK_CYC)) u_tick (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .tb(tb.tick_src)
   );

   cycle_timer u_cyc (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .tb(tb.cyc)
   );

   // ----------------------------------------------------------
   // enable and external threshold objects
   // ----------------------------------------------------------
   logic active_ff;
   logic nxt_active;
   logic [SPD_W-1:0] ext16_ff;
   logic [SPD_W-1:0] nxt_ext16;
   logic [7:0] ext8_ff;
   logic [7:0] nxt_ext8;
   logic seen16_ff;
   logic nxt_seen16;
   logic seen8_ff;
   logic nxt_seen8;

   always_comb begin
      nxt_active = i_wind_en & i_both_en;
      nxt_ext16 = i_ext16_wr ? i_ext16 : ext16_ff;
      nxt_ext8 = i_ext8_wr ? i_ext8 : ext8_ff;
      nxt_seen16 = seen16_ff | i_ext16_wr;
      nxt_seen8 = seen8_ff | i_ext8_wr;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         active_ff <= 1'b0;
         ext16_ff <= '0;
         ext8_ff <= '0;
         seen16_ff <= 1'b0;
         seen8_ff <= 1'b0;
      end else begin
         active_ff <= nxt_active;
         ext16_ff <= nxt_ext16;
         ext8_ff <= nxt_ext8;
         seen16_ff <= nxt_seen16;
         seen8_ff <= nxt_seen8;
      end
   end

   // ----------------------------------------------------------
   // threshold, hysteresis band and comparator
   // ----------------------------------------------------------
   logic [SPD_W-1:0] thr;
   logic [SPD_W-1:0] hyst;
   logic [SPD_W-1:0] low;
   logic [SPD_W:0] high;
   logic under_mode;
   logic pri_hit;
   logic ret_hit;
   act_e act_pri;
   act_e act_ret;
   act_e act;
   logic mute;
   logic cond_ff;
   logic nxt_cond;
   logic cvld_ff;
   logic nxt_cvld;
   logic tgt_ff;
   logic nxt_tgt;

   always_comb begin
      if (i_ext_mode == EXT_16 && seen16_ff) begin
         thr = ext16_ff;
      end else if (i_ext_mode == EXT_8 && seen8_ff) begin
         thr = ext8_speed(ext8_ff);
      end else begin
         thr = level_speed(i_threshold_level);
      end
      hyst = hyst_speed(i_hyst_sel);
      low = (thr > hyst) ? thr - hyst : '0;
      high = {1'b0, thr} + {1'b0, hyst};
      under_mode = i_action_sel[1];
      if (under_mode) begin
         pri_hit = i_speed < thr;
         ret_hit = {1'b0, i_speed} > high;
      end else begin
         pri_hit = i_speed > thr;
         ret_hit = i_speed < low;
      end
      // one-sided modes leave one crossing without a telegram
      if (i_action_sel >= MODE_RET_ONLY) begin
         act_pri = ACT_NONE;
      end else begin
         act_pri = i_action_sel[0] ? ACT_OFF : ACT_ON;
      end
      if ((i_action_sel >= MODE_PRI_ONLY && i_action_sel < MODE_RET_ONLY) || i_action_sel >= MODE_CNT) begin
         act_ret = ACT_NONE;
      end else begin
         act_ret = i_action_sel[0] ? ACT_ON : ACT_OFF;
      end
      act = !cvld_ff ? ACT_NONE : (cond_ff ? act_pri : act_ret);
      mute = cvld_ff && act == ACT_NONE;
      nxt_cond = cond_ff;
      nxt_cvld = cvld_ff;
      if (!active_ff) begin
         nxt_cond = 1'b0;
         nxt_cvld = 1'b0;
      end else if (i_speed_vld) begin
         if (pri_hit) begin
            nxt_cond = 1'b1;
            nxt_cvld = 1'b1;
         end else if (ret_hit) begin
            nxt_cond = 1'b0;
            nxt_cvld = 1'b1;
         end
      end
      nxt_tgt = tgt_ff;
      if (!active_ff) begin
         nxt_tgt = 1'b0;
      end else if (act == ACT_ON) begin
         nxt_tgt = 1'b1;
      end else if (act == ACT_OFF) begin
         nxt_tgt = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cond_ff <= 1'b0;
         cvld_ff <= 1'b0;
         tgt_ff <= 1'b0;
      end else begin
         cond_ff <= nxt_cond;
         cvld_ff <= nxt_cvld;
         tgt_ff <= nxt_tgt;
      end
   end

   a_exceed_sets: assert property (active_ff && i_speed_vld && !i_action_sel[1] && i_speed > thr
      |=> cond_ff && cvld_ff) else $error("exceed crossing not taken");
   a_exceed_return: assert property (active_ff && i_speed_vld && !i_action_sel[1] && i_speed < low
      |=> !cond_ff && cvld_ff) else $error("exceed return not taken");
   a_under_sets: assert property (active_ff && i_speed_vld && i_action_sel[1] && i_speed < thr
      |=> cond_ff && cvld_ff) else $error("undershoot crossing not taken");
   a_under_return: assert property (active_ff && i_speed_vld && i_action_sel[1] && {1'b0, i_speed} > high
      |=> !cond_ff && cvld_ff) else $error("undershoot return not taken");
   a_hyst_hold: assert property (active_ff && i_speed_vld && !i_action_sel[1] && i_speed <= thr
      && i_speed >= low |=> $stable(cond_ff)) else $error("state moved inside band");
   a_level_table: assert property (i_ext_mode == EXT_NONE && i_threshold_level == 4'h4
      |-> thr == 16'h0050) else $error("wrong threshold level");
   a_ext16_used: assert property (i_ext_mode == EXT_16 && seen16_ff
      |-> thr == ext16_ff) else $error("external 16-bit threshold ignored");
   a_ext8_used: assert property (i_ext_mode == EXT_8 && seen8_ff && ext8_ff == 8'h80
      |-> thr == 16'h00c8) else $error("external 8-bit threshold not scaled");

   // ----------------------------------------------------------
   // switch-on and switch-off delay
   // ----------------------------------------------------------
   logic state_ff;
   logic nxt_state;
   dly_st_e st_ff;
   dly_st_e nxt_st;
   logic [SEC_W-1:0] dly_ff;
   logic [SEC_W-1:0] nxt_dly;
   logic [SEC_W-1:0] dsec;
   logic want;
   logic accept;

   always_comb begin
      want = tgt_ff != state_ff;
      dsec = delay_secs(tgt_ff ? i_on_dly_sel : i_off_dly_sel);
      nxt_st = st_ff;
      nxt_dly = dly_ff;
      accept = 1'b0;
      unique case (st_ff)
         ST_IDLE: begin
            if (active_ff && want) begin
               if (dsec == '0) begin
                  accept = 1'b1;
               end else begin
                  nxt_dly = dsec;
                  nxt_st = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (!active_ff || !want) begin
               nxt_st = ST_IDLE;
            end else if (tb.tick) begin
               if (dly_ff == 12'h001) begin
                  accept = 1'b1;
                  nxt_st = ST_IDLE;
               end else begin
                  nxt_dly = dly_ff - 1'b1;
               end
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff <= ST_IDLE;
         dly_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         dly_ff <= nxt_dly;
      end
   end

   a_on_delay: assert property (active_ff && $rose(state_ff) && delay_secs($past(i_on_dly_sel)) != '0
      |-> $past(tb.tick)) else $error("rise accepted before delay end");
   a_off_delay: assert property (active_ff && $fell(state_ff) && delay_secs($past(i_off_dly_sel)) != '0
      |-> $past(tb.tick)) else $error("fall accepted before delay end");
   a_delay_load: assert property (st_ff == ST_IDLE && active_ff && want && dsec != '0
      |=> st_ff == ST_WAIT && dly_ff == $past(dsec)) else $error("delay count not loaded");
   a_cancel_wait: assert property (st_ff == ST_WAIT && active_ff && !want
      |=> st_ff == ST_IDLE && $stable(state_ff)) else $error("reverted state not cancelled");

   // ----------------------------------------------------------
   // accepted state and telegram requests
   // ----------------------------------------------------------
   logic send_ff;
   logic nxt_send;
   logic val_ff;
   logic nxt_val;
   logic chg_send;
   logic cyc_send;

   always_comb begin
      if (!active_ff) begin
         nxt_state = 1'b0;
      end else if (accept) begin
         nxt_state = tgt_ff;
      end else begin
         nxt_state = state_ff;
      end
      chg_send = accept && i_send_chg && !mute;
      cyc_send = tb.due && !mute;
      nxt_send = active_ff && (chg_send || cyc_send);
      nxt_val = nxt_state;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= 1'b0;
         send_ff <= 1'b0;
         val_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         send_ff <= nxt_send;
         val_ff <= nxt_val;
      end
   end

   assign tb.run = active_ff;
   assign tb.cyc_sel = (i_cyc_sel > CYC_MAX) ? CYC_MAX : i_cyc_sel;

   a_inactive_quiet: assert property (!active_ff
      |=> !send_ff && !state_ff) else $error("inactive monitor still active");
   a_mute_cyclic: assert property (mute && tb.due
      |=> !send_ff) else $error("cyclic telegram sent while muted");
   a_send_value: assert property (send_ff && $past(st_ff) == ST_WAIT && !$past(accept)
      |-> val_ff == $past(state_ff)) else $error("telegram value not the accepted state");
   a_change_sent: assert property (active_ff && accept && i_send_chg && !mute
      |=> send_ff && val_ff == $past(tgt_ff)) else $error("accepted change not sent");
   a_send_cause: assert property (send_ff
      |-> $past(tb.due) || $past(i_send_chg)) else $error("telegram without cause");
   a_cyc_zero: assert property (i_cyc_sel == 7'h00 ##1 i_cyc_sel == 7'h00
      |-> !tb.due) else $error("cyclic pulse with setting zero");
   a_cyc_sent: assert property (active_ff && tb.due && !mute
      |=> send_ff) else $error("cyclic telegram missing");

   assign o_state = state_ff;
   assign o_send = send_ff;
   assign o_send_val = val_ff;
   assign o_active = active_ff;
endmodule

// >>> test/bus_sink_model.sv
// Purpose: installation bus side that receives threshold telegrams
// Assumes: one telegram per cycle with o_send high
// Notes: keeps a cycle count so the bench can measure send intervals
module bus_sink_model (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_send,
   input wire logic i_send_val,
   output int o_rx_cnt,
   output logic o_last_val,
   output longint o_last_cyc
);
   timeunit 1ns;
   timeprecision 100ps;
   longint cyc_cnt = 0;

   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_cnt <= 0;
         o_last_val <= 1'b0;
      end else if (i_send === 1'b1) begin
         o_rx_cnt <= o_rx_cnt + 1;
         o_last_val <= i_send_val;
         o_last_cyc <= cyc_cnt;
      end
   end

   always @(posedge i_clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
   end
endmodule

// >>> test/tb_wind_speed_threshold_monitor.sv
// Purpose: self-checking bench of the wind threshold monitor
// Assumes: short seconds tick of TK cycles
// Notes: expected telegram values queue up, a monitor pops one per send
module tb_wind_speed_threshold_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   import wsm_pkg::*;
   localparam int TK = 10;
   logic clk = 0, rst_n = 0, wind_en = 1, both_en = 0, vld = 0, ext16_wr = 0, ext8_wr = 0, send_chg = 0;
   logic [15:0] speed = '0, ext16 = '0;
   logic [7:0] ext8 = '0;
   logic [3:0] lvl = 4'h4, act = '0, on_dly = '0, off_dly = '0;
   logic [2:0] hyst = 3'h1;
   logic [1:0] ext_mode = '0;
   logic [6:0] cyc = '0;
   logic st, snd, sval, act_o, last_val;
   int rx_cnt, n_mismatch = 0, checks = 0, seed = 32'hb611aa28;
   longint last_cyc, t0;
   logic exp_q[$];
   int lv_tab[12] = '{10, 30, 50, 80, 100, 120, 150, 200, 220, 250, 300, 350};
   int hy_tab[6] = '{0, 10, 30, 50, 80, 100};
   int pa[13] = '{1, 0, 1, 0, 1, 0, 1, 0, 2, 2, 2, 2, 2};
   int ra[13] = '{0, 1, 0, 1, 2, 2, 2, 2, 0, 1, 0, 1, 2};
   int thr_tab[3] = '{80, 200, 200};
   logic ep;

   wind_speed_threshold_monitor #(.P_TICK_CYC(TK)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wind_en(wind_en),
      .i_both_en(both_en), .i_speed(speed), .i_speed_vld(vld), .i_threshold_level(lvl), .i_hyst_sel(hyst),
      .i_action_sel(act), .i_ext_mode(ext_mode), .i_ext16(ext16), .i_ext16_wr(ext16_wr), .i_ext8(ext8),
      .i_ext8_wr(ext8_wr), .i_on_dly_sel(on_dly), .i_off_dly_sel(off_dly), .i_send_chg(send_chg),
      .i_cyc_sel(cyc), .o_state(st), .o_send(snd), .o_send_val(sval), .o_active(act_o));

   bus_sink_model sink (.i_clk_sys(clk), .i_rst_n(rst_n), .i_send(snd), .i_send_val(sval),
      .o_rx_cnt(rx_cnt), .o_last_val(last_val), .o_last_cyc(last_cyc));

   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_num(input string nm, input logic signed [63:0] e, input logic signed [63:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // stimulus tasks
   // ----------------------------------------
   task automatic cfg(input logic [3:0] l, input logic [2:0] h, input logic [3:0] m, input logic [3:0] ond,
                      input logic [3:0] offd, input logic chg, input logic [6:0] cy);
      @(posedge clk);
      lvl <= l;
      hyst <= h;
      act <= m;
      on_dly <= ond;
      off_dly <= offd;
      send_chg <= chg;
      cyc <= cy;
      rst_n <= 1'b0;
      exp_q.delete();
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic sample(input int s);
      @(posedge clk);
      speed <= 16'(s);
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic wait_q(input int lim);
      for (int i = 0; i < lim && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         chk_num("pending sends", 0, exp_q.size());
         exp_q.delete();
      end
      #1;
   endtask

   // ----------------------------------------
   // telegram monitor and watchdog
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst_n === 1'b1 && snd === 1'b1) begin
         if (exp_q.size() == 0)
            chk_bit("unexpected send", 1'b0, 1'b1);
         else
            chk_bit("send value", exp_q.pop_front(), sval);
      end
   end

   initial begin
      forever #12.5 clk = ~clk;
   end

   initial begin
      // about three times the expected run length
      #(25 * 6000);
      n_mismatch++;
      complete_run();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      cfg(4'h4, 3'h1, 4'h0, 4'h0, 4'h0, 1'b1, 7'h00);
      sample(90);
      chk_bit("active", 1'b0, act_o);
      chk_bit("state", 1'b0, st);
      @(posedge clk);
      both_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk_bit("active", 1'b1, act_o);
      @(posedge clk);
      wind_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_bit("active without wind", 1'b0, act_o);
      @(posedge clk);
      wind_en <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         cfg(4'(i + 1), 3'h0, 4'h0, 4'h0, 4'h0, 1'b0, 7'h00);
         sample(lv_tab[i]);
         chk_bit("state at level", 1'b0, st);
         sample(lv_tab[i] + 1);
         chk_bit("state above level", 1'b1, st);
         sample(lv_tab[i] - 1);
         chk_bit("state below level", 1'b0, st);
      end
      for (int j = 0; j < 6; j++) begin
         cfg(4'hc, 3'(j), 4'h0, 4'h0, 4'h0, 1'b0, 7'h00);
         sample(351);
         sample(350 - hy_tab[j]);
         chk_bit("state in band", 1'b1, st);
         sample(349 - hy_tab[j]);
         chk_bit("state below band", 1'b0, st);
      end
      for (int m = 0; m < 13; m++) begin
         cfg(4'h4, 3'h1, 4'(m), 4'h0, 4'h0, 1'b0, 7'h00);
         sample((m % 4) < 2 ? 90 : 70);
         ep = (pa[m] == 2) ? 1'b0 : 1'(pa[m]);
         chk_bit("mode first crossing", ep, st);
         sample((m % 4) < 2 ? 60 : 100);
         ep = (ra[m] == 2) ? ep : 1'(ra[m]);
         chk_bit("mode return crossing", ep, st);
      end
      cfg(4'h4, 3'h1, 4'h0, 4'h0, 4'h0, 1'b1, 7'h00);
      exp_q.push_back(1'b1);
      sample(90);
      for (int k = 0; k < 8; k++) sample(70 + ($unsigned($random(seed)) % 11));
      exp_q.push_back(1'b0);
      sample(69);
      wait_q(5);
      chk_bit("state after band", 1'b0, st);
      cfg(4'h4, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0, 7'h00);
      sample(90);
      sample(60);
      repeat (300) @(posedge clk);
      chk_num("telegram count", 0, rx_cnt);
      for (int e = 0; e < 3; e++) begin
         cfg(4'h4, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0, 7'h00);
         @(posedge clk);
         ext_mode <= 2'(e);
         ext16 <= 16'h00c8;
         ext8 <= 8'h80;
         ext16_wr <= 1'b1;
         ext8_wr <= 1'b1;
         @(posedge clk);
         ext16_wr <= 1'b0;
         ext8_wr <= 1'b0;
         sample(thr_tab[e]);
         chk_bit("state at ext level", 1'b0, st);
         sample(thr_tab[e] + 1);
         chk_bit("state above ext level", 1'b1, st);
      end
      @(posedge clk);
      ext_mode <= 2'h0;
      cfg(4'h4, 3'h1, 4'h0, 4'hd, 4'h0, 1'b0, 7'h02);
      sample(90);
      exp_q.push_back(1'b0);
      wait_q(450);
      t0 = last_cyc;
      exp_q.push_back(1'b0);
      wait_q(450);
      chk_num("cyclic interval", 2 * 10 * TK, last_cyc - t0);
      chk_bit("state while delayed", 1'b0, st);
      chk_bit("last telegram value", 1'b0, last_val);
      cfg(4'h4, 3'h1, 4'h0, 4'h2, 4'h2, 1'b1, 7'h00);
      sample(90);
      sample(60);
      repeat (50) @(posedge clk);
      #1;
      chk_bit("state after cancel", 1'b0, st);
      for (int d = 0; d < 2; d++) begin
         exp_q.push_back(1'(1 - d));
         sample(d == 0 ? 90 : 60);
         repeat (17) @(posedge clk);
         #1;
         chk_bit("state before delay", 1'(d), st);
         repeat (14) @(posedge clk);
         #1;
         chk_bit("state after delay", 1'(1 - d), st);
         wait_q(5);
      end
      cfg(4'h4, 3'h1, 4'h4, 4'h0, 4'h0, 1'b1, 7'h01);
      repeat (3) exp_q.push_back(1'b1);
      sample(90);
      wait_q(350);
      sample(60);
      repeat (300) @(posedge clk);
      chk_num("telegrams with mute", 3, rx_cnt);
      complete_run();
   end
endmodule
